//--- odt_pkg.sv
// Shared constants and types for the termination control link
package odt_pkg;
   // ====================================================
   // Link command set and termination states
   typedef enum logic [2:0] {
      CMD_NOP, CMD_WR8, CMD_WR4, CMD_RD,
      CMD_MRS1, CMD_MRS2, CMD_SRE, CMD_SRX
   } link_cmd_t;
   typedef enum logic [1:0] {TERM_OFF, TERM_NOM, TERM_WR} term_t;
   localparam int ARG_W = 11;

   // ====================================================
   // Mode register field positions
   localparam int MR1_B2 = 2;
   localparam int MR1_B6 = 6;
   localparam int MR1_B9 = 9;
   localparam int MR2_WR_LO = 9;
   localparam int MR2_CWL_LO = 3;
   // Nominal codes, {b9,b6,b2}
   localparam logic [2:0] NOM_OFF = 3'h0;
   localparam logic [2:0] NOM_DIV4 = 3'h1;
   localparam logic [2:0] NOM_DIV2 = 3'h2;
   localparam logic [2:0] NOM_DIV6 = 3'h3;
   localparam logic [2:0] NOM_DIV12 = 3'h4;
   localparam logic [2:0] NOM_DIV8 = 3'h5;
   localparam logic [2:0] NOM_RSVD = 3'h6;
   // Write codes, {b10,b9}
   localparam logic [1:0] WR_OFF = 2'h0;
   localparam logic [1:0] WR_DIV4 = 2'h1;
   localparam logic [1:0] WR_DIV2 = 2'h2;
   localparam int RZQ_OHM = 240;

   // ====================================================
   // Latencies in link clocks
   localparam int CWL_BASE = 5;
   localparam int ODTL_ADJ = 2;
   localparam int ODTH4 = 4;
   localparam int ODTH8 = 6;
   // Reset low time
   localparam int CLK_NS = 40;
   localparam int RST_MIN_NS = 100;
   localparam int RST_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;

   // ====================================================
   // Controller register map and fields
   localparam logic [3:0] REG_PINS = 4'h0;
   localparam logic [3:0] REG_CMD = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam int PIN_ODT = 0;
   localparam int PIN_CKE = 1;
   localparam int PIN_RST = 2;
   localparam int CMD_ARG_LO = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Nominal code to ohms, reserved reads as zero
   function automatic logic [7:0] nom_ohms(input logic [2:0] c);
      logic [7:0] r;
      r = 8'h00;
      unique case (c)
         NOM_DIV2: r = 8'(RZQ_OHM / 2);
         NOM_DIV4: r = 8'(RZQ_OHM / 4);
         NOM_DIV6: r = 8'(RZQ_OHM / 6);
         NOM_DIV8: r = 8'(RZQ_OHM / 8);
         NOM_DIV12: r = 8'(RZQ_OHM / 12);
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // Write code to ohms
   function automatic logic [7:0] wr_ohms(input logic [1:0] c);
      return (c == WR_DIV2) ? 8'(RZQ_OHM / 2) :
         (c == WR_DIV4) ? 8'(RZQ_OHM / 4) : 8'h00;
   endfunction
endpackage

//--- odt_link_if.sv
// Link between memory controller and DRAM termination logic
`timescale 1ns/1ns
interface odt_link_if;
   import odt_pkg::*;
   logic ck;                // Link clock, made by the controller
   logic reset_n;           // Active low DRAM reset
   logic cke;               // Clock enable
   logic odt;               // Termination request
   link_cmd_t cmd;          // Command, one link clock long
   logic [ARG_W-1:0] arg;   // Mode register value for MRS
   modport ctrl(output ck, reset_n, cke, odt, cmd, arg);
   modport dram(input ck, reset_n, cke, odt, cmd, arg);
endinterface

//--- odt_sync2.sv
// Two flip-flop synchroniser for a bundle of pins
`timescale 1ns/1ns
module odt_sync2 #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;    // First stage, read only by s2
      logic [W-1:0] s2;    // Second stage
   } sync_t;
   sync_t s;
   sync_t next_s;

   // ====================================================
   // Stage shift
   always_comb begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.s2;
endmodule

//--- dram_odt_ctl.sv
// DRAM end: on-die termination control and reset response
// What this block and the controller end do
// R1 - MR1 bits 9,6,2 enable nominal, ODT switches
// R2 - Controller never programs nominal codes 110, 111
// R3 - ODT ignored in self refresh or all disabled
// R4 - Controller keeps ODT low on reads, refresh
// R5 - ODT low during write is legal
// R6 - Nominal value is 240 ohms over n
// R7 - Nominal during writes limited to /2,/4,/6
// R8 - Nominal only after init, not read, refresh
// R9 - Sync turn-on at CWL plus AL minus 2
// R10 - Sync turn-off at same latency
// R11 - Async mode follows ODT without clock latency
// R12 - Controller holds ODT high 4 or 6 clocks
// R13 - No termination in DLL disable mode
// R14 - Async when DLL off or relocking
// R15 - Write termination only during writes, no MRS
// R16 - Write value for burst, then back nominal
// R17 - Low reset acts any time, held 100ns
// R18 - Reset turns termination off, resets internals
// R19 - Controller drives CKE low before reset release
// R20 - Reset clears state, full init required after
// R21 - Dynamic on when MR2 bit 9 or 10 set
// R22 - Write value after fixed latency, BL8/BC4 end
// R23 - Each clock derive off, nominal or write
`timescale 1ns/1ns
module dram_odt_ctl
   import odt_pkg::*;
#(
   parameter int AL = 0,      // Additive latency, link clocks
   parameter int HIST = 32    // Depth of the link history
) (
   input wire logic aclk,
   input wire logic aresetn,
   odt_link_if.dram link,
   input wire logic dll_disable,
   input wire logic dll_async,
   output term_t term_state,
   output logic [7:0] term_ohms,
   output logic self_refresh
);

   // ====================================================
   // State
   typedef struct packed {
      logic ck_prev;            // Synced link clock, last cycle
      logic [HIST-1:0] odt_h;   // ODT level per link edge
      logic [HIST-1:0] w8_h;    // BL8 write per link edge
      logic [HIST-1:0] w4_h;    // BC4 write per link edge
      logic [HIST-1:0] rd_h;    // Read per link edge
      logic [2:0] nom;          // Nominal termination code
      logic [1:0] wr;           // Write termination code
      logic [2:0] cwl;          // CAS write latency code
      logic self_ref;           // In self refresh
      logic inited;             // MR1 loaded since reset
      term_t term;              // Applied termination
      logic [7:0] ohms;         // Applied value in ohms
   } dev_t;

   dev_t s;
   dev_t next_s;

   // Synchronised pins
   logic ck_s;
   logic rst_n_s;
   logic odt_s;
   link_cmd_t cmd_s;
   logic [ARG_W-1:0] arg_s;
   logic [2:0] cmd_raw;

   // ====================================================
   // Pin synchroniser
   // The controller changes cmd and arg half a link clock
   // away from the rising edge, so the bundle is stable
   // when the synced edge is seen.
   odt_sync2 #(
      .W(6 + ARG_W)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({link.ck, link.reset_n, link.odt, link.cmd, link.arg}),
      .q({ck_s, rst_n_s, odt_s, cmd_raw, arg_s})
   );
   assign cmd_s = link_cmd_t'(cmd_raw);

   // ====================================================
   // Window test on a history vector
   function automatic logic in_win(
      input logic [HIST-1:0] h,
      input int lo,
      input int n
   );
      logic r;
      r = 1'b0;
      for (int i = 0; i < HIST; i++) begin
         if (i >= lo && i < lo + n) begin
            r = r | h[i];
         end
      end
      return r;
   endfunction

   // ====================================================
   // Next state
   always_comb begin
      logic ck_rise;
      int lat;
      logic odt_eff;
      logic dyn;
      logic wr_win;
      logic rd_busy;
      logic ignore;
      ck_rise = 1'b0;
      lat = 0;
      odt_eff = 1'b0;
      dyn = 1'b0;
      wr_win = 1'b0;
      rd_busy = 1'b0;
      ignore = 1'b0;
      next_s = s;
      ck_rise = ck_s && !s.ck_prev;
      next_s.ck_prev = ck_s;

      // Register ODT and command at each link rising edge
      if (ck_rise) begin
         next_s.odt_h = {s.odt_h[HIST-2:0], odt_s};
         next_s.w8_h = {s.w8_h[HIST-2:0], cmd_s == CMD_WR8};
         next_s.w4_h = {s.w4_h[HIST-2:0], cmd_s == CMD_WR4};
         next_s.rd_h = {s.rd_h[HIST-2:0], cmd_s == CMD_RD};
         unique case (cmd_s)
            // Nominal enable from MR1 bits 9,6,2
            CMD_MRS1: begin
               next_s.nom = {arg_s[MR1_B9], arg_s[MR1_B6],
                  arg_s[MR1_B2]}; // R1
               next_s.inited = 1'b1; // R8
            end
            // Write code and CWL from MR2
            CMD_MRS2: begin
               next_s.wr = arg_s[MR2_WR_LO +: 2]; // R21
               next_s.cwl = arg_s[MR2_CWL_LO +: 3];
            end
            CMD_SRE: next_s.self_ref = 1'b1;
            CMD_SRX: next_s.self_ref = 1'b0;
            default: begin
               // NOP, reads and writes change no mode state
            end
         endcase
      end

      // ODTLon = ODTLoff = CWL + AL - 2
      lat = int'(next_s.cwl) + CWL_BASE + AL - ODTL_ADJ;

      // Async mode bypasses the latency line
      if (dll_async) begin
         odt_eff = odt_s; // R11 R14
      end else begin
         odt_eff = next_s.odt_h[lat]; // R9 R10
      end

      // Dynamic mode needs a write code and a running DLL
      dyn = (next_s.wr != WR_OFF) && !dll_disable; // R21 R13
      // Write value from ODTLcnw up to ODTLcwn4 or ODTLcwn8
      wr_win = dyn && (in_win(next_s.w8_h, lat, ODTH8) ||
         in_win(next_s.w4_h, lat, ODTH4)); // R15 R16 R22

      // A read masks termination until its burst is gone
      rd_busy = in_win(next_s.rd_h, 0, lat + ODTH8); // R8

      // ODT pin ignored in these conditions
      ignore = next_s.self_ref ||
         (next_s.nom == NOM_OFF && next_s.wr == WR_OFF); // R3
      // No termination at all with the DLL disabled
      ignore = ignore || dll_disable; // R13
      // Not before init, not during reads; reserved is safe off
      ignore = ignore || !next_s.inited || rd_busy ||
         (next_s.nom >= NOM_RSVD); // R8

      // Off, nominal or write, recomputed every clock
      if (ignore || !odt_eff) begin
         next_s.term = TERM_OFF; // R23
      end else if (wr_win) begin
         next_s.term = TERM_WR; // R15
      end else if (next_s.nom != NOM_OFF) begin
         next_s.term = TERM_NOM; // R16
      end else begin
         // Nominal disabled outside a write
         next_s.term = TERM_OFF;
      end

      // Value follows the applied state
      unique case (next_s.term)
         TERM_NOM: next_s.ohms = nom_ohms(next_s.nom); // R6
         TERM_WR: next_s.ohms = wr_ohms(next_s.wr);
         default: next_s.ohms = 8'h00;
      endcase

      // Link reset clears everything, termination high-Z
      if (!rst_n_s) begin
         next_s = '0; // R17 R18 R20
      end
   end

   // ====================================================
   // State register; all-zero state means termination off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ====================================================
   // Outputs, all straight from the state register
   assign term_state = s.term;
   assign term_ohms = s.ohms;
   assign self_refresh = s.self_ref;

endmodule

//--- odt_host.sv
// Controller end: drives link pins from AXI4-Lite registers
`timescale 1ns/1ns
module odt_host
   import odt_pkg::*;
#(
   parameter int CK_HALF = 4   // aclk cycles per link half period
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [3:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [3:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   odt_link_if.ctrl link
);

   // ====================================================
   // State
   typedef struct packed {
      logic awready, wready, bvalid, arready, rvalid;
      logic aw_got, w_got;
      logic [3:0] waddr;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic [1:0] bresp;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] pins;        // Software pin requests
      logic busy;              // Command waiting for a link edge
      logic [2:0] pend;        // Waiting command
      logic [ARG_W-1:0] parg;  // Waiting argument
      logic err;               // Sticky refusal flag
      logic [7:0] div;         // Link clock divider
      logic [7:0] rcnt;        // Reset low time
      logic [3:0] hold;        // ODT high hold, link clocks
      logic [2:0] nom;         // Shadow of nominal code
      logic [1:0] wr;          // Shadow of write code
      logic inited;            // MR1 written since reset
      logic ck, reset_n, cke, odt;
      logic [2:0] cmd;
      logic [ARG_W-1:0] arg;
   } host_t;

   host_t s;
   host_t next_s;

   // ====================================================
   // Next state
   always_comb begin
      logic fall;
      logic want_odt;
      link_cmd_t c;
      fall = 1'b0;
      want_odt = 1'b0;
      c = link_cmd_t'(s.pend);
      next_s = s;

      // AXI channels
      if (awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.waddr = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wdat = wdata;
         next_s.wstb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // Register write once address and data are both held
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         unique case (s.waddr)
            REG_PINS: if (s.wstb[0]) next_s.pins = s.wdat[2:0];
            REG_CMD: begin
               c = link_cmd_t'(s.wdat[2:0]);
               // Refuse busy, partial or illegal orders
               if (s.busy || s.wstb != 4'hF ||
                  (c == CMD_MRS1 && {s.wdat[CMD_ARG_LO + MR1_B9],
                  s.wdat[CMD_ARG_LO + MR1_B6],
                  s.wdat[CMD_ARG_LO + MR1_B2]} >= NOM_RSVD) || // R2
                  ((c == CMD_RD || c == CMD_SRE) && s.odt) || // R4
                  ((c == CMD_WR8 || c == CMD_WR4) && s.odt &&
                  s.wr == WR_OFF && s.nom > NOM_DIV6)) begin // R7
                  next_s.err = 1'b1;
               end else begin
                  // A write with ODT low is accepted as is
                  next_s.busy = 1'b1; // R5
                  next_s.pend = s.wdat[2:0];
                  next_s.parg = s.wdat[CMD_ARG_LO +: ARG_W];
               end
            end
            REG_STAT: if (s.wstb[0] && s.wdat[1]) next_s.err = 1'b0;
            default: next_s.bresp = RESP_SLVERR;
         endcase
      end

      // Register read
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         unique case (araddr)
            REG_PINS: next_s.rdata = {29'h0, s.pins};
            REG_CMD: next_s.rdata = {5'h0, s.parg, 13'h0, s.pend};
            REG_STAT: next_s.rdata = {27'h0, |s.hold,
               !s.reset_n, s.odt, s.err, s.busy};
            default: begin
               next_s.rdata = 32'h0;
               next_s.rresp = RESP_SLVERR;
            end
         endcase
      end
      // Refusal raised in the same cycle beats a clear
      if (s.aw_got && s.w_got && !s.bvalid && s.waddr == REG_CMD &&
         !next_s.busy) begin
         next_s.err = next_s.err | (s.busy == 1'b0 ? 1'b0 : 1'b1);
      end

      // Link clock divider; pins change on the falling edge, except reset_n and cke going low
      if (s.div == 8'(CK_HALF - 1)) begin
         next_s.div = 8'h00;
         next_s.ck = !s.ck;
         fall = s.ck;
      end else begin
         next_s.div = s.div + 8'h01;
      end

      // Reset hold count, at least 100 ns low
      if (s.pins[PIN_RST]) begin
         next_s.rcnt = 8'h00;
      end else if (s.rcnt < 8'(RST_CYC)) begin
         next_s.rcnt = s.rcnt + 8'h01;
      end

      if (fall) begin
         // Commands last one link clock
         next_s.cmd = CMD_NOP;
         if (s.busy) begin
            next_s.cmd = s.pend;
            next_s.arg = s.parg;
            next_s.busy = 1'b0;
            if (s.pend == CMD_MRS1) begin
               next_s.nom = {s.parg[MR1_B9], s.parg[MR1_B6],
                  s.parg[MR1_B2]};
               next_s.inited = 1'b1;
            end
            if (s.pend == CMD_MRS2) next_s.wr = s.parg[MR2_WR_LO +: 2];
         end
         // ODT only after init; self refresh is not tracked here
         want_odt = s.pins[PIN_ODT] && s.inited; // R8
         if (s.hold != 4'h0) next_s.hold = s.hold - 4'h1;
         // Hold ODT high for ODTH4 or ODTH8 link clocks
         if (want_odt && !s.odt) next_s.hold = 4'(ODTH4); // R12
         if (s.odt && s.busy && s.pend == CMD_WR8) begin
            next_s.hold = 4'(ODTH8); // R12
         end else if (s.odt && s.busy && s.pend == CMD_WR4 &&
            s.hold < 4'(ODTH4)) begin
            next_s.hold = 4'(ODTH4); // R12
         end
         next_s.odt = want_odt || (s.odt && s.hold > 4'h1);
      end

      // Reset low; CKE low while in reset and at release
      if (s.pins[PIN_RST] || s.rcnt < 8'(RST_CYC)) begin
         next_s.reset_n = 1'b0; // R17
         next_s.cke = 1'b0; // R19
         if (fall) next_s.odt = 1'b0;
         next_s.hold = 4'h0;
         next_s.inited = 1'b0; // R20
         next_s.nom = NOM_OFF;
         next_s.wr = WR_OFF;
      end else if (fall) begin
         next_s.reset_n = 1'b1;
         next_s.cke = s.pins[PIN_CKE] && s.reset_n; // R19
      end

      // Ready flags follow the next occupancy
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   // ====================================================
   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ====================================================
   // Outputs straight from flops
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign link.ck = s.ck;
   assign link.reset_n = s.reset_n;
   assign link.cke = s.cke;
   assign link.odt = s.odt;
   assign link.cmd = link_cmd_t'(s.cmd);
   assign link.arg = s.arg;
endmodule

//--- odt_link_monitor.sv
// Checker for the termination link between controller and DRAM ends
`timescale 1ns/1ns
module odt_link_monitor
   import odt_pkg::*;
(
   input logic aclk,
   input logic aresetn,
   input logic ck,
   input logic reset_n,
   input logic cke,
   input logic odt,
   input link_cmd_t cmd,
   input logic [ARG_W-1:0] arg
);
   // ==================================================
   // Helper logic
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic ck_q;          // Link clock one cycle ago
   logic odt_r;         // Termination request at last link rise
   logic [3:0] cnt;     // Link rises with the request held high
   logic [3:0] need;    // Minimum hold owed, 4 or 6
   wire ck_rise = ck && !ck_q;
   // Track the hold owed; a write restarts the count
   always_ff @(posedge aclk) begin
      ck_q <= ck;
      if (!aresetn) begin
         odt_r <= 1'b0;
         cnt <= 4'h0;
         need <= 4'h4;
      end else if (ck_rise) begin
         odt_r <= odt;
         if (odt && (!odt_r || cmd == CMD_WR8 || cmd == CMD_WR4)) begin
            cnt <= 4'h1;
            need <= (cmd == CMD_WR8) ? 4'h6 : 4'h4;
         end else if (odt && cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
   // ==================================================
   // Properties
   property p_rst_hold;
      $fell(reset_n) |-> !reset_n [*3];
   endproperty
   property p_odt_hold;
      (ck_rise && odt_r && !odt) |-> cnt >= need;
   endproperty
   property p_rd_odt;
      (ck_rise && cmd == CMD_RD) |-> !odt;
   endproperty
   property p_sre_odt;
      (ck_rise && cmd == CMD_SRE) |-> !odt;
   endproperty
   property p_mrs1_code;
      (ck_rise && cmd == CMD_MRS1) |-> !(arg[MR1_B9] && arg[MR1_B6]);
   endproperty
   property p_pins_setup;
      $rose(ck) |-> $stable(odt) && $stable(cmd) && $stable(arg);
   endproperty
   property p_ck_half;
      $rose(ck) |-> ck [*4] ##1 !ck;
   endproperty
   property p_reset_vals;
      $rose(aresetn) |-> !ck && !reset_n && !odt && !cke && cmd == CMD_NOP;
   endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("link reset released too early");
   a_odt_hold: assert property (p_odt_hold)
      else $error("termination request dropped too soon");
   a_rd_odt: assert property (p_rd_odt)
      else $error("read sent with termination requested");
   a_sre_odt: assert property (p_sre_odt)
      else $error("self refresh entered with termination requested");
   a_mrs1_code: assert property (p_mrs1_code)
      else $error("reserved nominal code sent");
   a_pins_setup: assert property (p_pins_setup)
      else $error("link pins moved at a link rising edge");
   a_ck_half: assert property (p_ck_half)
      else $error("link clock high phase wrong");
   a_reset_vals: assert property (p_reset_vals)
      else $error("link pins not idle after reset");
   // Scenarios reached
   c_odt_rise: cover property ($rose(odt));
   c_wr8: cover property (ck_rise && cmd == CMD_WR8 && odt);
   c_rst_fall: cover property ($fell(reset_n));
endmodule

//--- dram_termination_and_reset_control_tb_top.sv
// Testbench joining controller and DRAM ends over the link
`timescale 1ns/1ns
module dram_termination_and_reset_control_tb_top;
   import odt_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rv;     // rv holds the last read word
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;    // resp holds the last response
   logic dll_disable, dll_async, self_refresh;
   term_t term_state;
   logic [7:0] term_ohms;
   int failures, n_tests;
   int dv [1:5] = '{4, 2, 6, 12, 8};  // Divisor per nominal code
   odt_link_if odt_link_if_i();
   odt_host odt_host_i(.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .link(odt_link_if_i));
   dram_odt_ctl dram_odt_ctl_i(.aclk(aclk), .aresetn(aresetn),
      .link(odt_link_if_i), .dll_disable(dll_disable),
      .dll_async(dll_async), .term_state(term_state),
      .term_ohms(term_ohms), .self_refresh(self_refresh));
   odt_link_monitor odt_link_monitor_i(.aclk(aclk), .aresetn(aresetn),
      .ck(odt_link_if_i.ck), .reset_n(odt_link_if_i.reset_n),
      .cke(odt_link_if_i.cke), .odt(odt_link_if_i.odt),
      .cmd(odt_link_if_i.cmd), .arg(odt_link_if_i.arg));
   // ==================================================
   // Clock and watchdog
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Cut off far beyond the expected run
   initial begin
      #(40 * 60000);
      failures++;
      close_out();
   end
   // ==================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Write: address and data together, each dropped when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (bvalid && !awvalid && !wvalid) break;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (rvalid && !arvalid) break;
         if (arready) arvalid <= 1'b0;
      end
      rv = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [10:0] m1(input logic [2:0] c);
      logic [10:0] a;
      a = 11'h000;
      a[MR1_B9] = c[2];
      a[MR1_B6] = c[1];
      a[MR1_B2] = c[0];
      return a;
   endfunction
   // Send a link command; wait until sent and seen
   task automatic cmd(input link_cmd_t c, input logic [10:0] a);
      wr(REG_CMD, (32'(a) << CMD_ARG_LO) | 32'(c));
      do rd(REG_STAT); while (rv[0] !== 1'b0);
      repeat (8) @(posedge aclk);
   endtask
   // Bounded wait for a termination state, then check
   task automatic wt(input term_t t, input int oh);
      int n;
      n = 0;
      while (term_state !== t && n < 600) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(term_state), 32'(t));
      chk(32'(term_ohms), 32'(oh));
   endtask
   // Expect error flag set; write one clears it
   task automatic err_seen;
      rd(REG_STAT);
      chk(32'(rv[1]), 32'h1);
      wr(REG_STAT, 32'h2);
   endtask
   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==================================================
   // Main sequence
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wstrb, wdata} = 44'h0;
      {dll_disable, dll_async} = 2'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wt(TERM_OFF, 0);
      rd(4'hC);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(4'hC, 32'h0);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(REG_PINS, 32'h2);
      do rd(REG_STAT); while (rv[3] !== 1'b0);
      // Each legal nominal code, switched by the request pin
      for (int c = 1; c <= 5; c++) begin
         cmd(CMD_MRS1, m1(3'(c)));
         wr(REG_PINS, 32'h3);
         wt(TERM_NOM, RZQ_OHM / dv[c]);
         wr(REG_PINS, 32'h2);
         wt(TERM_OFF, 0);
      end
      cmd(CMD_MRS1, m1(NOM_RSVD));
      err_seen();
      // Write termination swaps in for each burst length
      cmd(CMD_MRS1, m1(NOM_DIV2));
      cmd(CMD_MRS2, 11'h001 << MR2_WR_LO);
      wr(REG_PINS, 32'h3);
      wt(TERM_NOM, RZQ_OHM / 2);
      cmd(CMD_WR8, 11'h000);
      wt(TERM_WR, RZQ_OHM / 4);
      wt(TERM_NOM, RZQ_OHM / 2);
      cmd(CMD_WR4, 11'h000);
      wt(TERM_WR, RZQ_OHM / 4);
      wt(TERM_NOM, RZQ_OHM / 2);
      cmd(CMD_RD, 11'h000);
      err_seen();
      dll_disable <= 1'b1;
      wt(TERM_OFF, 0);
      dll_disable <= 1'b0;
      wt(TERM_NOM, RZQ_OHM / 2);
      dll_async <= 1'b1;
      wr(REG_PINS, 32'h2);
      wt(TERM_OFF, 0);
      wr(REG_PINS, 32'h3);
      wt(TERM_NOM, RZQ_OHM / 2);
      // Self refresh ignores the request pin
      wr(REG_PINS, 32'h2);
      wt(TERM_OFF, 0);
      dll_async <= 1'b0;
      cmd(CMD_SRE, 11'h000);
      chk(32'(self_refresh), 32'h1);
      wr(REG_PINS, 32'h3);
      repeat (80) @(posedge aclk);
      chk(32'(term_state), 32'(TERM_OFF));
      wr(REG_PINS, 32'h2);
      cmd(CMD_SRX, 11'h000);
      chk(32'(self_refresh), 32'h0);
      cmd(CMD_RD, 11'h000);
      // Link reset forces off, forgets mode codes
      wr(REG_PINS, 32'h3);
      wt(TERM_NOM, RZQ_OHM / 2);
      wr(REG_PINS, 32'h7);
      wt(TERM_OFF, 0);
      wr(REG_PINS, 32'h0);
      do rd(REG_STAT); while (rv[3] !== 1'b0);
      wr(REG_PINS, 32'h3);
      repeat (100) @(posedge aclk);
      chk(32'(term_state), 32'(TERM_OFF));
      close_out();
   end
endmodule
